// ---- clock_panel_pkg.sv ----
// Purpose: shared constants and carriers for the clock supply panel and phase meter
// Assumes: one 200 MHz clock, APB register access
// Notes:   offsets are byte addresses of 32-bit words
package clock_panel_pkg;

    localparam int unsigned CLK_HZ      = 200_000_000;
    localparam int unsigned METER_HZ    = 8_000;
    localparam int unsigned UPDATE_MS   = 1_000;
    localparam int unsigned UPDATE_CYC  = (CLK_HZ / 1_000) * UPDATE_MS;
    localparam int unsigned PERIOD_CYC  = CLK_HZ / METER_HZ;
    localparam int unsigned PERIOD_TOL  = PERIOD_CYC / 16;
    localparam logic [15:0] PER_MIN     = 16'(PERIOD_CYC - PERIOD_TOL);
    localparam logic [15:0] PER_MAX     = 16'(PERIOD_CYC + PERIOD_TOL);
    localparam logic [6:0]  FULL_COUNT  = 7'h40;
    localparam int unsigned DIV_STEPS   = 7;

    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_LAMPS   = 8'h04;
    localparam logic [7:0]  OFS_METER   = 8'h08;
    localparam logic [7:0]  OFS_FORCE   = 8'h0C;

    localparam int unsigned CTRL_METER_EN = 0;
    localparam int unsigned CTRL_FALL_ONE = 1;
    localparam int unsigned CTRL_FALL_TWO = 2;
    localparam logic [2:0]  CTRL_RESET    = 3'h0;
    localparam int unsigned METER_SHOWN   = 8;
    localparam int unsigned METER_BAD     = 9;

    // synchronised pin vector positions
    localparam int unsigned PIN_RELEASE = 0;
    localparam int unsigned PIN_BLOCK_A = 1;
    localparam int unsigned PIN_BLOCK_B = 2;
    localparam int unsigned PIN_FREERUN = 3;
    localparam int unsigned PIN_SILENCE = 4;
    localparam int unsigned PIN_SUPRST  = 5;
    localparam int unsigned PIN_IN_ONE  = 6;
    localparam int unsigned PIN_IN_TWO  = 7;

    typedef struct packed {
        logic [1:0] framing_lost;
        logic       source_b;
        logic [1:0] input_ok;
        logic       reference_refused;
        logic [1:0] free_run;
        logic [1:0] fast_start;
        logic [1:0] half_range;
        logic [1:0] slip;
        logic       no_track;
        logic       b_slaved;
        logic [1:0] loop_defect;
        logic [1:0] out_from_b;
        logic [1:0] output_fault;
    } status_s;

    typedef struct packed {
        logic [1:0] framing_lost;
        logic [1:0] source;
        logic [1:0] input_ok;
        logic       reference_refused;
        logic [1:0] autonomous_oscillation;
        logic [1:0] quick_acquire;
        logic [1:0] range_limit;
        logic [1:0] slip;
        logic       no_track;
        logic       loop_b_slaved;
        logic [1:0] loop_off;
        logic [3:0] path;
        logic [1:0] output_fault;
    } lamp_s;

    typedef struct packed {
        logic block_a;
        logic block_b;
        logic free_run;
    } force_s;

    typedef struct packed {
        logic       release_all_key;
        logic       loop_a_block_key;
        logic       loop_b_block_key;
        logic       free_run_key;
        logic       audible_silence_key;
        logic       supervisor_reset_key;
    } keys_s;

endpackage : clock_panel_pkg

// ---- clock_panel.sv ----
// Purpose: status lamps, operator keys and phase meter of a redundant clock supply
// Assumes: status arrives from logic on pclk; keys and meter inputs are raw pins
// Notes:   registers over APB with one wait state
//
// Contract
// - meter reports phase as 00 to 64
// - count shown as two decimal seven-segment digits
// - new measurement displayed once per second
// - per-input rising or falling edge select
// - bad input lights lamp, blanks display
// - red framing lost lamp per interface
// - green source lamp per interface unit
// - green input ok lamp per loop
// - red reference refused lamp
// - red free-run and fast-start lamps per loop
// - red range limit lamp at half range
// - red slip lamp per loop
// - red lamp when loop outputs diverge
// - red lamp while loop B slaved
// - red off lamp: inhibited or defective
// - four green path lamps per output circuit; the code has two per output circuit, four in all
// - red fault lamp per output circuit
// - four interlocking keys, two momentary keys
// - release key clears interlocking keys
// - block key removes loop feed while engaged
// - free-run key: A free-runs, B slaved
// - reset and audible silence key actions
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module clock_panel #(
    parameter int unsigned SECOND_CYC = clock_panel_pkg::UPDATE_CYC
) (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic                          pready,
    output logic [31:0]                   prdata,
    output logic                          pslverr,
    // panel pins
    input  wire clock_panel_pkg::keys_s   keys,
    input  wire logic                     meter_input_one,
    input  wire logic                     meter_input_two,
    // status from loops, interfaces and output circuits
    input  wire clock_panel_pkg::status_s status,
    // lamps and display
    output clock_panel_pkg::lamp_s        lamps,
    output logic                          bad_input_lamp,
    output logic [6:0]                    digit_tens,
    output logic [6:0]                    digit_ones,
    // force conditions to the supply
    output clock_panel_pkg::force_s       force_state,
    output logic                          supervisor_reset_pulse,
    output logic                          audible_silence_pulse
);
    import clock_panel_pkg::*;

    typedef struct packed {
        logic [7:0]       s1;
        logic [7:0]       s2;
        logic [7:0]       s3;
        force_s           frc;
        logic             rst_p;
        logic             aco_p;
        logic [1:0][15:0] per_cnt;
        logic [1:0]       in_ok;
        logic [15:0]      p_lat;
        logic [15:0]      d_cnt;
        logic             d_run;
        logic [31:0]      sec_cnt;
        logic             busy;
        logic [3:0]       step;
        logic [22:0]      rem;
        logic [6:0]       quo;
        logic [6:0]       count;
        logic             meas_ok;
        logic [2:0]       ctrl;
        lamp_s            lmp;
        logic             bad;
        logic             shown;
        logic [6:0]       shown_cnt;
        logic [6:0]       seg_t;
        logic [6:0]       seg_o;
        logic             rdy;
        logic [31:0]      rdata;
        logic             err;
    } state_s;

    state_s st_q;
    state_s st_d;

    ////////////////////////////////////////////////////////////////////////
    // decimal digit to segments g..a, active high
    function automatic logic [6:0] seg_of(input logic [3:0] v);
        unique case (v)
            4'h0: seg_of = 7'h3F;
            4'h1: seg_of = 7'h06;
            4'h2: seg_of = 7'h5B;
            4'h3: seg_of = 7'h4F;
            4'h4: seg_of = 7'h66;
            4'h5: seg_of = 7'h6D;
            4'h6: seg_of = 7'h7D;
            4'h7: seg_of = 7'h07;
            4'h8: seg_of = 7'h7F;
            4'h9: seg_of = 7'h6F;
            default: seg_of = 7'h00;
        endcase
    endfunction : seg_of

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  pins;
    logic [7:0]  rise;
    logic [7:0]  fall;
    logic [1:0]  ev;
    logic [22:0] sub;
    logic [3:0]  tens;
    logic [3:0]  ones;
    logic [31:0] rd;
    logic        hit;

    assign pins = {meter_input_two, meter_input_one, keys.supervisor_reset_key, keys.audible_silence_key,
                   keys.free_run_key, keys.loop_b_block_key, keys.loop_a_block_key, keys.release_all_key};

    always_comb begin
        st_d = st_q;
        // first stage feeds only the second
        st_d.s1 = pins;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        rise = st_q.s2 & ~st_q.s3;
        fall = st_q.s3 & ~st_q.s2;

        // interlocking latched keys: last pressed wins, release clears all
        if (rise[PIN_RELEASE]) begin
            st_d.frc = '0;
        end else if (rise[PIN_BLOCK_A]) begin
            st_d.frc = '{block_a: 1'b1, block_b: 1'b0, free_run: 1'b0};
        end else if (rise[PIN_BLOCK_B]) begin
            st_d.frc = '{block_a: 1'b0, block_b: 1'b1, free_run: 1'b0};
        end else if (rise[PIN_FREERUN]) begin
            st_d.frc = '{block_a: 1'b0, block_b: 1'b0, free_run: 1'b1};
        end
        // holding a momentary key gives one action only
        st_d.rst_p = rise[PIN_SUPRST];
        st_d.aco_p = rise[PIN_SILENCE];

        // lamps
        st_d.lmp.framing_lost           = status.framing_lost;
        st_d.lmp.source                 = {status.source_b, ~status.source_b};
        st_d.lmp.input_ok               = status.input_ok;
        st_d.lmp.reference_refused      = status.reference_refused;
        // forced free run shows at once, before the loops report it
        st_d.lmp.autonomous_oscillation = status.free_run | {1'b0, st_q.frc.free_run};
        st_d.lmp.quick_acquire          = status.fast_start;
        st_d.lmp.range_limit            = status.half_range;
        st_d.lmp.slip                   = status.slip;
        st_d.lmp.no_track               = status.no_track;
        st_d.lmp.loop_b_slaved          = status.b_slaved | st_q.frc.free_run;
        st_d.lmp.loop_off               = status.loop_defect | {st_q.frc.block_b, st_q.frc.block_a};
        st_d.lmp.path                   = {status.out_from_b[1], ~status.out_from_b[1],
                                           status.out_from_b[0], ~status.out_from_b[0]};
        st_d.lmp.output_fault           = status.output_fault;

        // per-input edge choice and period check
        ev[0] = st_q.ctrl[CTRL_FALL_ONE] ? fall[PIN_IN_ONE] : rise[PIN_IN_ONE];
        ev[1] = st_q.ctrl[CTRL_FALL_TWO] ? fall[PIN_IN_TWO] : rise[PIN_IN_TWO];
        for (int i = 0; i < 2; i++) begin
            if (ev[i]) begin
                st_d.per_cnt[i] = 16'h0001;
                st_d.in_ok[i]   = (st_q.per_cnt[i] >= PER_MIN) && (st_q.per_cnt[i] <= PER_MAX);
            end else if (st_q.per_cnt[i] > PER_MAX) begin
                // absent input: no edge within the longest period
                st_d.in_ok[i] = 1'b0;
            end else begin
                st_d.per_cnt[i] = st_q.per_cnt[i] + 16'h0001;
            end
        end
        if (ev[0]) begin
            st_d.p_lat = st_q.per_cnt[0];
        end

        // delay from input one edge to input two edge
        sub = 23'h0;
        if (ev[0]) begin
            st_d.d_cnt = 16'h0000;
            st_d.d_run = 1'b1;
        end else if (st_q.d_run) begin
            st_d.d_cnt = st_q.d_cnt + 16'h0001;
        end
        if (ev[1] && st_q.d_run && !st_q.busy) begin
            // rounded delay*64/period, so a near-full cycle reads 64
            st_d.rem   = {1'b0, st_q.d_cnt, 6'h00} + {8'h00, st_q.p_lat[15:1]};
            st_d.quo   = 7'h00;
            st_d.step  = 4'(DIV_STEPS);
            st_d.busy  = 1'b1;
        end else if (st_q.busy) begin
            sub = 23'({7'h00, st_q.p_lat} << (st_q.step - 4'h1));
            if (st_q.rem >= sub) begin
                st_d.rem = st_q.rem - sub;
                st_d.quo = st_q.quo | 7'(7'h01 << (st_q.step - 4'h1));
            end
            st_d.step = st_q.step - 4'h1;
            if (st_q.step == 4'h1) begin
                st_d.busy    = 1'b0;
                st_d.meas_ok = 1'b1;
            end
        end
        if (st_q.busy && st_q.step == 4'h1) begin
            st_d.count = (st_d.quo > FULL_COUNT) ? FULL_COUNT : st_d.quo;
        end

        // once-per-second display update
        tens = 4'h0;
        ones = 4'h0;
        if (st_q.sec_cnt >= 32'(SECOND_CYC - 1)) begin
            st_d.sec_cnt = 32'h0;
            tens = 4'(st_q.count / 7'd10);
            ones = 4'(st_q.count % 7'd10);
            st_d.bad = st_q.ctrl[CTRL_METER_EN] && !(&st_q.in_ok);
            if (st_q.ctrl[CTRL_METER_EN] && (&st_q.in_ok) && st_q.meas_ok) begin
                st_d.shown     = 1'b1;
                st_d.shown_cnt = st_q.count;
                st_d.seg_t     = seg_of(tens);
                st_d.seg_o     = seg_of(ones);
            end else begin
                st_d.shown = 1'b0;
                st_d.seg_t = 7'h00;
                st_d.seg_o = 7'h00;
            end
        end else begin
            st_d.sec_cnt = st_q.sec_cnt + 32'h1;
        end
        // meter switched off blanks at once rather than at the next tick
        if (!st_q.ctrl[CTRL_METER_EN]) begin
            st_d.shown = 1'b0;
            st_d.bad   = 1'b0;
            st_d.seg_t = 7'h00;
            st_d.seg_o = 7'h00;
        end

        // apb: access phase answered on its second cycle
        hit = 1'b1;
        rd  = 32'h0;
        unique case (paddr)
            OFS_CTRL:  rd = {29'h0, st_q.ctrl};
            OFS_LAMPS: rd = {7'h0, st_q.lmp};
            OFS_METER: rd = {22'h0, st_q.bad, st_q.shown, 1'b0, st_q.shown_cnt};
            OFS_FORCE: rd = {29'h0, st_q.frc};
            default:   hit = 1'b0;
        endcase
        st_d.rdy = 1'b0;
        if (psel && penable && !st_q.rdy) begin
            st_d.rdy   = 1'b1;
            st_d.err   = !hit;
            st_d.rdata = pwrite ? 32'h0 : rd;
        end else if (!psel) begin
            st_d.err   = 1'b0;
            st_d.rdata = 32'h0;
        end
        // write lands on the edge that samples pready high, a cycle after the edge that raises it
        if (psel && penable && st_q.rdy && pwrite && paddr == OFS_CTRL) begin
            st_d.ctrl = pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q      <= '0;
            st_q.ctrl <= CTRL_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign pready                 = st_q.rdy;
    assign prdata                 = st_q.rdata;
    assign pslverr                = st_q.err;
    assign lamps                  = st_q.lmp;
    assign bad_input_lamp         = st_q.bad;
    assign digit_tens             = st_q.seg_t;
    assign digit_ones             = st_q.seg_o;
    assign force_state            = st_q.frc;
    assign supervisor_reset_pulse = st_q.rst_p;
    assign audible_silence_pulse  = st_q.aco_p;

endmodule : clock_panel

// ---- loop_status_model.sv ----
// Purpose: far-side status source and two 8 kHz loop outputs
// Assumes: pclk at 200 MHz, status is same-clock logic
// Notes:   wave_two lags wave_one by SHIFT cycles
`timescale 1ns/1ps
module loop_status_model #(
    parameter int unsigned SHIFT = 6250
) (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // requested and driven status
    input  wire clock_panel_pkg::status_s want,
    output clock_panel_pkg::status_s      status,
    // loop outputs
    output logic                          wave_one,
    output logic                          wave_two
);
    import clock_panel_pkg::*;
    int unsigned cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt    <= 0;
            status <= '0;
        end else begin
            cnt    <= (cnt == PERIOD_CYC - 1) ? 0 : cnt + 1;
            status <= want;
        end
    end
    // half duty: falling edges sit half a period after rising ones
    assign wave_one = cnt < PERIOD_CYC / 2;
    assign wave_two = ((cnt + PERIOD_CYC - SHIFT) % PERIOD_CYC) < PERIOD_CYC / 2;
endmodule : loop_status_model

// ---- clock_panel_properties.sv ----
// Purpose: port-level checks of the clock panel
// Assumes: lamps follow status by one cycle
// Notes:   bound to every clock_panel
`timescale 1ns/1ps
module clock_panel_properties #(
    parameter int unsigned SECOND_CYC = 1
) (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire clock_panel_pkg::keys_s   keys,
    input wire clock_panel_pkg::status_s status,
    input wire clock_panel_pkg::lamp_s   lamps,
    input wire logic                     bad_input_lamp,
    input wire logic [6:0]               digit_tens,
    input wire logic [6:0]               digit_ones,
    input wire clock_panel_pkg::force_s  force_state,
    input wire logic                     supervisor_reset_pulse,
    input wire logic                     audible_silence_pulse
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    reset_pulse_one_a: assert property (supervisor_reset_pulse |=> !supervisor_reset_pulse)
        else $error("reset pulse longer than one cycle");
    silence_pulse_one_a: assert property (audible_silence_pulse |=> !audible_silence_pulse)
        else $error("silence pulse longer than one cycle");
    force_onehot_a: assert property ($onehot0(force_state))
        else $error("more than one interlocking key active");
    blank_when_bad_a: assert property (bad_input_lamp |-> digit_tens == 7'h00 && digit_ones == 7'h00)
        else $error("digits shown with bad input");
    source_lamp_map_a: assert property ($past(presetn) |-> lamps.source == {$past(status.source_b),
        !$past(status.source_b)}) else $error("source lamps wrong");
    path_lamp_map_a: assert property ($past(presetn) |-> lamps.path == {$past(status.out_from_b[1]),
        !$past(status.out_from_b[1]), $past(status.out_from_b[0]), !$past(status.out_from_b[0])})
        else $error("path lamps wrong");
    block_lamp_on_a: assert property (force_state.block_a |-> ##[0:2] lamps.loop_off[0])
        else $error("blocked loop not shown off");
    release_clears_a: assert property ($rose(keys.release_all_key) |-> ##[1:6] force_state == 3'h0)
        else $error("release key left a force set");
    freerun_slaves_a: assert property (force_state.free_run |-> ##[0:2]
        (lamps.loop_b_slaved && lamps.autonomous_oscillation[0])) else $error("free run lamps missing");
    cover property (force_state.free_run);
    cover property (audible_silence_pulse);
    cover property (digit_tens != 7'h00);
    cover property (bad_input_lamp);
endmodule : clock_panel_properties
bind clock_panel clock_panel_properties #(.SECOND_CYC(SECOND_CYC)) i_props (.pclk, .presetn, .keys, .status,
    .lamps, .bad_input_lamp, .digit_tens, .digit_ones, .force_state, .supervisor_reset_pulse, .audible_silence_pulse);

// ---- tb_timing_supply_status_phase_meter.sv ----
// Purpose: self-checking bench for the clock panel
// Assumes: one wait state on APB, 30000-cycle second
// Notes:   meter inputs come from the loop model
`timescale 1ns/1ps
module tb_timing_supply_status_phase_meter;
    import clock_panel_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic w1, w2, bad, se, rp, sp, er;
    logic [6:0] dt, d1;
    keys_s keys = '0;
    status_s want = '0, st;
    lamp_s lamps;
    force_s fs;
    int err_total = 0, check_count = 0, cyc = 0, rpn = 0, spn = 0;
    force_s fx [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
    int     kx [4] = '{4, 3, 2, 5};
    always #2.5 pclk = ~pclk;
    clock_panel #(.SECOND_CYC(30000)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .keys, .meter_input_one(w1), .meter_input_two(w2), .status(st), .lamps,
        .bad_input_lamp(bad), .digit_tens(dt), .digit_ones(d1), .force_state(fs),
        .supervisor_reset_pulse(rp), .audible_silence_pulse(sp));
    loop_status_model i_far (.pclk, .presetn, .want, .status(st), .wave_one(w1), .wave_two(w2));
    ////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    always @(posedge pclk) begin
        cyc++;
        rpn += (rp === 1'b1);
        spn += (sp === 1'b1);
        if (cyc > 70000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // no local limit: the cycle ceiling ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    function automatic lamp_s exp_l(input status_s s, input force_s f);
        lamp_s l;
        l = '{s.framing_lost, {s.source_b, !s.source_b}, s.input_ok, s.reference_refused, s.free_run | {1'b0, f.free_run},
            s.fast_start, s.half_range, s.slip, s.no_track, s.b_slaved | f.free_run, s.loop_defect | {f.block_b, f.block_a},
            {s.out_from_b[1], !s.out_from_b[1], s.out_from_b[0], !s.out_from_b[0]}, s.output_fault};
        return l;
    endfunction : exp_l
    task automatic lamp_chk(input status_s s, input force_s f);
        @(posedge pclk);
        want <= s;
        repeat (4) @(posedge pclk);
        chk("lamps", 32'(lamps), 32'(exp_l(s, f)));
    endtask : lamp_chk
    // held long enough to prove one action per press
    task automatic press(input int k);
        @(posedge pclk);
        keys <= keys_s'(6'h01 << k);
        repeat (8) @(posedge pclk);
        keys <= '0;
        repeat (3) @(posedge pclk);
    endtask : press
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        chk("digits off", {dt, d1}, 14'h0);
        // both inputs on falling edges: delay 6250 of 25000 cycles reads 16
        apb(1, OFS_CTRL, 32'h7);
        apb(0, OFS_CTRL, 0);
        chk("ctrl", rd, 32'h7);
        apb(0, 8'h10, 0);
        chk("slverr", er, 1'b1);
        $display("test registers done");
        for (int i = 0; i < 22; i++) lamp_chk(status_s'(22'h1 << i), 3'h0);
        lamp_chk('1, 3'h0);
        apb(0, OFS_LAMPS, 0);
        chk("lamp reg", rd, 32'(exp_l('1, 3'h0)));
        lamp_chk('0, 3'h0);
        $display("test lamps done");
        for (int i = 0; i < 4; i++) begin
            press(kx[i]);
            chk("force", fs, fx[i]);
            lamp_chk('0, fx[i]);
        end
        apb(0, OFS_FORCE, 0);
        chk("force reg", rd, 32'h0);
        press(1);
        press(0);
        chk("pulses", {16'(rpn), 16'(spn)}, 32'h0001_0001);
        $display("test keys done");
        // first tick: neither input has a full valid period yet
        wait (cyc == 30040);
        chk("bad input", {bad, dt, d1}, {1'b1, 14'h0});
        wait (cyc == 60040);
        chk("digits", {bad, dt, d1}, {1'b0, 7'h06, 7'h7D});
        apb(0, OFS_METER, 0);
        chk("meter reg", rd, 32'h110);
        apb(1, OFS_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        chk("meter off", {bad, dt, d1}, 15'h0);
        $display("test meter done");
        wrap_up();
    end
endmodule : tb_timing_supply_status_phase_meter
